// file: common/spr_regs.svh
// register offsets, field positions and reset values of the special register bank
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// -----------------------------------------------------------------------------
// byte offsets on the register bus
// -----------------------------------------------------------------------------
`define OFF_MSR   12'h000
`define OFF_LR    12'h004
`define OFF_CTR   12'h008
`define OFF_XER   12'h00C
`define OFF_TBL   12'h010
`define OFF_TBU   12'h014
`define OFF_DATA_STORAGE_CAUSE_REG 12'h018
`define OFF_DAR   12'h01C
`define OFF_DEC   12'h020
`define OFF_SDR   12'h024
`define OFF_SAVE_RESTORE_ADDR_REG  12'h028
`define OFF_SAVE_RESTORE_STATUS_REG  12'h02C
`define OFF_EAR   12'h030
`define OFF_PVR   12'h034
`define OFF_INSTR_BREAKPOINT_REG  12'h038
`define OFF_DATA_BREAKPOINT_REG  12'h03C
`define OFF_HID   12'h040
`define OFF_PIR   12'h044
`define OFF_PERF_COUNTER_ONE  12'h048
`define OFF_PERF_COUNTER_TWO  12'h04C
`define OFF_MMCR  12'h050
`define OFF_SIA   12'h054
`define OFF_SDA   12'h058
`define SPRG_BASE 8'h06
`define SR_BASE   6'h02
`define BAT_BASE  6'h03

// -----------------------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------------------
`define XER_OV      30
`define XER_CA      29
`define MSR_EXC_CLR 32'h0000_C000
`define MSR_RESET   32'h0000_0000
`define EAR_EN      31
`define INSTR_BREAKPOINT_REG_EN     1
`define DATA_BREAKPOINT_REG_WR_EN  1
`define DATA_BREAKPOINT_REG_RD_EN  0
`define PERF_COUNTER_ONE_SEL    0
`define PERF_COUNTER_ONE_EN     3
`define PERF_COUNTER_TWO_SEL    4
`define PERF_COUNTER_TWO_EN     7
`define PMC_IE      8
`define TB_DIV      2'h3

`endif

// file: common/spr_pkg.sv
// types shared by the special register bank
package spr_pkg;

   // whole state of the bank, registered in one place
   typedef struct packed {
      logic [31:0]       machine_state_reg, lr, ctr, fixed_point_exception_reg, time_base_lower, time_base_upper, data_storage_cause_reg, data_fault_address_reg, dec, page_table_descriptor_reg;
      logic [31:0]       save_restore_addr_reg, save_restore_status_reg, external_access_reg, instr_breakpoint_reg, data_breakpoint_reg, impl_control_reg, perf_counter_one, perf_counter_two, monitor_control_reg;
      logic [31:0]       sampled_instr_addr_reg, sda, rdata, seg_value;
      logic [3:0][31:0]  sprg;
      logic [15:0][31:0] sr;
      logic [15:0][31:0] block_translation_regs;
      logic [3:0]        processor_tag_reg;
      logic [1:0]        presc;
      logic              ready, slverr, priv_exc, dec_exc;
      logic              ibkpt, dbkpt, perf_exc, ctr_zero;
   } state_t;

endpackage

// file: design/spr_addr_match.sv
// address comparator for one breakpoint register
`timescale 1ns/1ns
`default_nettype none

module spr_addr_match #(
   parameter int LSB = 2
) (
   input  wire logic        valid,
   input  wire logic        enable,
   input  wire logic [31:0] ref_addr,
   input  wire logic [31:0] addr,
   output logic             hit
);

   // low bits below LSB are ignored, so one match covers a word or double word
   assign hit = valid & enable & (addr[31:LSB] == ref_addr[31:LSB]);

endmodule

`default_nettype wire

// file: design/spr_bank.sv
// special register bank with bus slave, time base and event capture
`timescale 1ns/1ns
`default_nettype none
`include "spr_regs.svh"

module spr_bank #(
   parameter logic [31:0] VERSION   = 32'h0001_0001, // arbitrary value
   parameter logic [3:0]  PIR_RESET = 4'h0
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   input  wire logic [2:0]  PPROT,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic [31:0]      PRDATA,
   input  wire logic        BRANCH_LINK,
   input  wire logic [31:0] RET_ADDR,
   input  wire logic        BRANCH_COUNT,
   input  wire logic        XER_UPDATE,
   input  wire logic        CARRY,
   input  wire logic        OVERFLOW,
   input  wire logic        EXC_TAKE,
   input  wire logic [31:0] EXC_ADDR,
   input  wire logic        RFI,
   input  wire logic        DSI_TAKE,
   input  wire logic [31:0] DSI_CAUSE,
   input  wire logic [31:0] DSI_ADDR,
   input  wire logic        TIME_BASE_COUNT_ENABLE,
   input  wire logic        FETCH_VALID,
   input  wire logic [31:0] FETCH_ADDR,
   input  wire logic        DATA_VALID,
   input  wire logic        DATA_WRITE,
   input  wire logic [31:0] DATA_ADDR,
   input  wire logic [7:0]  PERF_EVT,
   input  wire logic [3:0]  SEG_SEL,
   output logic [31:0]      MACHINE_STATE,
   output logic [31:0]      LINK_TARGET,
   output logic [31:0]      RESUME_ADDR,
   output logic             COUNT_ZERO,
   output logic             DEC_EXC,
   output logic             PRIV_EXC,
   output logic             IBKPT_EXC,
   output logic             DBKPT_EXC,
   output logic             PERF_EXC,
   output logic             EXT_ACCESS_EN,
   output logic [31:0]      IMPL_CTRL,
   output logic [3:0]       PROC_TAG,
   output logic [31:0]      SEG_VALUE
);

   localparam spr_pkg::state_t RESET_STATE = '{
      machine_state_reg:     `MSR_RESET,
      processor_tag_reg:     PIR_RESET,
      default: '0
   };

   spr_pkg::state_t q;
   spr_pkg::state_t next_q;
   logic            ihit;
   logic            dhit;

   // -----------------------------------------------------------------------
   // breakpoint comparators
   // -----------------------------------------------------------------------
   spr_addr_match #(.LSB(2)) imatch (
      .valid    (FETCH_VALID),
      .enable   (q.instr_breakpoint_reg[`INSTR_BREAKPOINT_REG_EN]),
      .ref_addr (q.instr_breakpoint_reg),
      .addr     (FETCH_ADDR),
      .hit      (ihit)
   );

   spr_addr_match #(.LSB(3)) dmatch (
      .valid    (DATA_VALID),
      .enable   (DATA_WRITE ? q.data_breakpoint_reg[`DATA_BREAKPOINT_REG_WR_EN] : q.data_breakpoint_reg[`DATA_BREAKPOINT_REG_RD_EN]),
      .ref_addr (q.data_breakpoint_reg),
      .addr     (DATA_ADDR),
      .hit      (dhit)
   );

   // byte-lane merge of write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   // -----------------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------------
   logic        setup;
   logic        wr;
   logic        sup;
   logic        hit;
   logic        user_rd;
   logic        user_wr;
   logic        denied;
   logic        tick;
   logic [31:0] rd;
   logic [31:0] dec_dn;
   logic [63:0] tb_up;
   logic [3:0]  idx;

   always_comb begin
      next_q  = q;
      setup   = PSEL & ~PENABLE;
      sup     = PPROT[0];
      wr      = PSEL & PENABLE & q.ready & PWRITE & ~q.slverr;
      hit     = 1'b1;
      user_rd = 1'b0;
      user_wr = 1'b0;
      rd      = '0;
      idx     = PADDR[5:2];
      tick    = (q.presc == `TB_DIV);
      dec_dn  = q.dec - 32'h0000_0001;
      tb_up   = {q.time_base_upper, q.time_base_lower} + 64'h0000_0000_0000_0001;

      // quarter-rate tick shared by time base and decrementer
      next_q.presc = tick ? 2'h0 : q.presc + 2'h1;
      if (tick && TIME_BASE_COUNT_ENABLE) begin
         next_q.time_base_upper = tb_up[63:32];
         next_q.time_base_lower = tb_up[31:0];
      end
      if (tick) begin
         next_q.dec = dec_dn;
      end
      // exception on the count passing through zero into negative values
      next_q.dec_exc = tick & ~q.dec[31] & dec_dn[31];

      // event counters, selected source per counter
      if (q.monitor_control_reg[`PERF_COUNTER_ONE_EN] && PERF_EVT[q.monitor_control_reg[`PERF_COUNTER_ONE_SEL +: 3]]) begin
         next_q.perf_counter_one = q.perf_counter_one + 32'h0000_0001;
      end
      if (q.monitor_control_reg[`PERF_COUNTER_TWO_EN] && PERF_EVT[q.monitor_control_reg[`PERF_COUNTER_TWO_SEL +: 3]]) begin
         next_q.perf_counter_two = q.perf_counter_two + 32'h0000_0001;
      end

      // register decode: readback, user permissions and writes
      case (PADDR)
         `OFF_MSR: begin
            rd = q.machine_state_reg;
            if (wr) next_q.machine_state_reg = merge(q.machine_state_reg, PWDATA, PSTRB);
         end
         `OFF_LR: begin
            rd = q.lr;
            user_rd = 1'b1;
            user_wr = 1'b1;
            if (wr) next_q.lr = merge(q.lr, PWDATA, PSTRB);
         end
         `OFF_CTR: begin
            rd = q.ctr;
            user_rd = 1'b1;
            user_wr = 1'b1;
            if (wr) next_q.ctr = merge(q.ctr, PWDATA, PSTRB);
         end
         `OFF_XER: begin
            rd = q.fixed_point_exception_reg;
            user_rd = 1'b1;
            user_wr = 1'b1;
            if (wr) next_q.fixed_point_exception_reg = merge(q.fixed_point_exception_reg, PWDATA, PSTRB);
         end
         `OFF_TBL: begin
            rd = q.time_base_lower;
            user_rd = 1'b1;
            if (wr) next_q.time_base_lower = merge(q.time_base_lower, PWDATA, PSTRB);
         end
         `OFF_TBU: begin
            rd = q.time_base_upper;
            user_rd = 1'b1;
            if (wr) next_q.time_base_upper = merge(q.time_base_upper, PWDATA, PSTRB);
         end
         `OFF_DATA_STORAGE_CAUSE_REG: begin
            rd = q.data_storage_cause_reg;
            if (wr) next_q.data_storage_cause_reg = merge(q.data_storage_cause_reg, PWDATA, PSTRB);
         end
         `OFF_DAR: begin
            rd = q.data_fault_address_reg;
            if (wr) next_q.data_fault_address_reg = merge(q.data_fault_address_reg, PWDATA, PSTRB);
         end
         `OFF_DEC: begin
            rd = q.dec;
            if (wr) next_q.dec = merge(q.dec, PWDATA, PSTRB);
         end
         `OFF_SDR: begin
            rd = q.page_table_descriptor_reg;
            if (wr) next_q.page_table_descriptor_reg = merge(q.page_table_descriptor_reg, PWDATA, PSTRB);
         end
         `OFF_SAVE_RESTORE_ADDR_REG: begin
            rd = q.save_restore_addr_reg;
            if (wr) next_q.save_restore_addr_reg = merge(q.save_restore_addr_reg, PWDATA, PSTRB);
         end
         `OFF_SAVE_RESTORE_STATUS_REG: begin
            rd = q.save_restore_status_reg;
            if (wr) next_q.save_restore_status_reg = merge(q.save_restore_status_reg, PWDATA, PSTRB);
         end
         `OFF_EAR: begin
            rd = q.external_access_reg;
            if (wr) next_q.external_access_reg = merge(q.external_access_reg, PWDATA, PSTRB);
         end
         `OFF_PVR: begin
            rd = VERSION;
         end
         `OFF_INSTR_BREAKPOINT_REG: begin
            rd = q.instr_breakpoint_reg;
            if (wr) next_q.instr_breakpoint_reg = merge(q.instr_breakpoint_reg, PWDATA, PSTRB);
         end
         `OFF_DATA_BREAKPOINT_REG: begin
            rd = q.data_breakpoint_reg;
            if (wr) next_q.data_breakpoint_reg = merge(q.data_breakpoint_reg, PWDATA, PSTRB);
         end
         `OFF_HID: begin
            rd = q.impl_control_reg;
            if (wr) next_q.impl_control_reg = merge(q.impl_control_reg, PWDATA, PSTRB);
         end
         `OFF_PIR: begin
            rd = {28'h000_0000, q.processor_tag_reg};
            if (wr && PSTRB[0]) next_q.processor_tag_reg = PWDATA[3:0];
         end
         `OFF_PERF_COUNTER_ONE: begin
            rd = q.perf_counter_one;
            if (wr) next_q.perf_counter_one = merge(q.perf_counter_one, PWDATA, PSTRB);
         end
         `OFF_PERF_COUNTER_TWO: begin
            rd = q.perf_counter_two;
            if (wr) next_q.perf_counter_two = merge(q.perf_counter_two, PWDATA, PSTRB);
         end
         `OFF_MMCR: begin
            rd = q.monitor_control_reg;
            if (wr) next_q.monitor_control_reg = merge(q.monitor_control_reg, PWDATA, PSTRB);
         end
         `OFF_SIA: begin
            rd = q.sampled_instr_addr_reg;
            if (wr) next_q.sampled_instr_addr_reg = merge(q.sampled_instr_addr_reg, PWDATA, PSTRB);
         end
         `OFF_SDA: begin
            rd = q.sda;
            if (wr) next_q.sda = merge(q.sda, PWDATA, PSTRB);
         end
         default: begin
            // arrays: scratch, segment and block translation words
            if (PADDR[11:4] == `SPRG_BASE && PADDR[1:0] == 2'b00) begin
               rd = q.sprg[idx[1:0]];
               if (wr) next_q.sprg[idx[1:0]] = merge(q.sprg[idx[1:0]], PWDATA, PSTRB);
            end else if (PADDR[11:6] == `SR_BASE && PADDR[1:0] == 2'b00) begin
               rd = q.sr[idx];
               if (wr) next_q.sr[idx] = merge(q.sr[idx], PWDATA, PSTRB);
            end else if (PADDR[11:6] == `BAT_BASE && PADDR[1:0] == 2'b00) begin
               rd = q.block_translation_regs[idx];
               if (wr) next_q.block_translation_regs[idx] = merge(q.block_translation_regs[idx], PWDATA, PSTRB);
            end else begin
               hit = 1'b0;
            end
         end
      endcase

      // user privilege only reaches the user-level words
      denied = ~sup & (PWRITE ? ~user_wr : ~user_rd);

      // answer prepared in the setup cycle, so access lasts one cycle
      next_q.ready    = setup;
      next_q.priv_exc = setup & hit & denied;
      if (setup) begin
         next_q.slverr = ~hit | denied;
         next_q.rdata  = (hit && !denied && !PWRITE) ? rd : 32'h0000_0000;
      end

      // implicit updates win over a bus write in the same cycle
      if (BRANCH_LINK) begin
         next_q.lr = RET_ADDR;
      end
      if (BRANCH_COUNT) begin
         next_q.ctr = q.ctr - 32'h0000_0001;
      end
      if (XER_UPDATE) begin
         next_q.fixed_point_exception_reg[`XER_CA] = CARRY;
         next_q.fixed_point_exception_reg[`XER_OV] = OVERFLOW;
      end
      if (DSI_TAKE) begin
         next_q.data_storage_cause_reg = DSI_CAUSE;
         next_q.data_fault_address_reg   = DSI_ADDR;
      end
      // return restores status; a new exception in the same cycle wins
      if (RFI) begin
         next_q.machine_state_reg = q.save_restore_status_reg;
      end
      if (EXC_TAKE) begin
         next_q.save_restore_addr_reg = EXC_ADDR;
         next_q.save_restore_status_reg = q.machine_state_reg;
         next_q.machine_state_reg  = q.machine_state_reg & ~`MSR_EXC_CLR;
      end

      // monitor interrupt on a counter turning negative
      next_q.perf_exc = q.monitor_control_reg[`PMC_IE] &
                        ((~q.perf_counter_one[31] & next_q.perf_counter_one[31]) | (~q.perf_counter_two[31] & next_q.perf_counter_two[31]));
      if (next_q.perf_exc) begin
         next_q.sampled_instr_addr_reg = FETCH_ADDR;
         next_q.sda = DATA_ADDR;
      end

      // breakpoints, zero test and segment lookup
      next_q.ibkpt     = ihit;
      next_q.dbkpt     = dhit;
      next_q.ctr_zero  = (next_q.ctr == 32'h0000_0000);
      next_q.seg_value = q.sr[SEG_SEL];
   end

   // -----------------------------------------------------------------------
   // state register; clock enable freezes everything
   // -----------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= RESET_STATE;
      end else if (CE) begin
         q <= next_q;
      end
   end

   // outputs straight from state
   assign PREADY        = q.ready;
   assign PSLVERR       = q.slverr;
   assign PRDATA        = q.rdata;
   assign MACHINE_STATE = q.machine_state_reg;
   assign LINK_TARGET   = q.lr;
   assign RESUME_ADDR   = q.save_restore_addr_reg;
   assign COUNT_ZERO    = q.ctr_zero;
   assign DEC_EXC       = q.dec_exc;
   assign PRIV_EXC      = q.priv_exc;
   assign IBKPT_EXC     = q.ibkpt;
   assign DBKPT_EXC     = q.dbkpt;
   assign PERF_EXC      = q.perf_exc;
   assign EXT_ACCESS_EN = q.external_access_reg[`EAR_EN];
   assign IMPL_CTRL     = q.impl_control_reg;
   assign PROC_TAG      = q.processor_tag_reg;
   assign SEG_VALUE     = q.seg_value;

   // -----------------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   link_capture_a: assert property (
      CE && BRANCH_LINK |=> LINK_TARGET == $past(RET_ADDR))
      else $error("link register missed return address");

   count_step_a: assert property (
      CE && BRANCH_COUNT |=> q.ctr == $past(q.ctr) - 32'h0000_0001 && COUNT_ZERO == (q.ctr == 32'h0))
      else $error("count register did not step");

   exc_save_a: assert property (
      CE && EXC_TAKE |=> RESUME_ADDR == $past(EXC_ADDR) && q.save_restore_status_reg == $past(q.machine_state_reg))
      else $error("exception save wrong");

   rfi_restore_a: assert property (
      CE && RFI && !EXC_TAKE |=> MACHINE_STATE == $past(q.save_restore_status_reg))
      else $error("status not restored on return");

   tb_count_a: assert property (
      CE && tick && TIME_BASE_COUNT_ENABLE && !wr |=> {q.time_base_upper, q.time_base_lower} == $past(tb_up))
      else $error("time base did not advance");

   tb_hold_a: assert property (
      CE && !wr && (!tick || !TIME_BASE_COUNT_ENABLE) |=> $stable({q.time_base_upper, q.time_base_lower}))
      else $error("time base moved off tick");

   tick_rate_a: assert property (
      CE && tick ##1 CE ##1 CE ##1 CE |-> !tick && !$past(tick, 1) && !$past(tick, 2))
      else $error("tick faster than quarter rate");

   dec_exc_a: assert property (
      DEC_EXC |-> $past(tick) && !$past(q.dec[31]) && $past(dec_dn[31]))
      else $error("decrementer exception without underflow");

   priv_deny_a: assert property (
      CE && setup && !PPROT[0] && PWRITE && PADDR == `OFF_MSR && !EXC_TAKE && !RFI
      ##1 CE && PSEL && PENABLE && !EXC_TAKE && !RFI
      |-> PRIV_EXC && PSLVERR ##1 !PRIV_EXC && $stable(MACHINE_STATE))
      else $error("user write reached state register");

   ibkpt_a: assert property (
      CE && ihit |=> IBKPT_EXC)
      else $error("instruction breakpoint missed");

   slave_answer_a: assert property (
      CE && setup |=> PREADY ##1 !PREADY || (CE && setup))
      else $error("bus answer timing wrong");

   lr_cov: cover property (CE && BRANCH_LINK ##1 LINK_TARGET == RET_ADDR);
   dec_cov: cover property (DEC_EXC);
   priv_cov: cover property (PRIV_EXC && PSLVERR);
   dbkpt_cov: cover property (DBKPT_EXC);

endmodule

`default_nettype wire

// file: test/spr_bank_tb.sv
// self-checking bench for the special register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, s); end end

module testbench;
   // --------------------------------------------------------------------------
   // stimulus and observation
   // --------------------------------------------------------------------------
   localparam logic [31:0] VERS = 32'h1234_5678; // arbitrary value
   logic             clk, rst_n, psel, pen, pwr, bl, bc, xu, cy, ov, et, rfi, dt, ten, fv, dv, dw, err, priv;
   logic             ce, clear;
   logic [11:0]      pa;
   logic [2:0]       pp;
   logic [3:0]       ssel, seen;
   logic [7:0]       evt;
   logic [31:0]      pwd, ra, ea, dc, dad, fa, daddr, rd;
   wire logic        prdy, perr, czero, dexc, pexc, ibk, dbk, pfx, eae;
   wire logic [31:0] prd, ms, lt, rs, ic, sv;
   wire logic [3:0]  tag;
   int               fails, comparisons, n;
   logic [11:0]      tab [10] = '{12'h004, 12'h008, 12'h024, 12'h060, 12'h064, 12'h068, 12'h06C, 12'h08C,
                                  12'h0C0, 12'h0FC};

   spr_bank #(.VERSION(VERS), .PIR_RESET(4'h0)) uut (.SYS_CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hF), .PPROT(pp), .PREADY(prdy),
      .PSLVERR(perr), .PRDATA(prd), .BRANCH_LINK(bl), .RET_ADDR(ra), .BRANCH_COUNT(bc), .XER_UPDATE(xu),
      .CARRY(cy), .OVERFLOW(ov), .EXC_TAKE(et), .EXC_ADDR(ea), .RFI(rfi), .DSI_TAKE(dt), .DSI_CAUSE(dc),
      .DSI_ADDR(dad), .TIME_BASE_COUNT_ENABLE(ten), .FETCH_VALID(fv), .FETCH_ADDR(fa), .DATA_VALID(dv),
      .DATA_WRITE(dw), .DATA_ADDR(daddr), .PERF_EVT(evt), .SEG_SEL(ssel), .MACHINE_STATE(ms),
      .LINK_TARGET(lt), .RESUME_ADDR(rs), .COUNT_ZERO(czero), .DEC_EXC(dexc), .PRIV_EXC(pexc),
      .IBKPT_EXC(ibk), .DBKPT_EXC(dbk), .PERF_EXC(pfx), .EXT_ACCESS_EN(eae), .IMPL_CTRL(ic),
      .PROC_TAG(tag), .SEG_VALUE(sv));

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // sticky record of one-cycle event pulses, so no pulse slips between looks
   always @(posedge clk) begin
      seen <= clear ? 4'h0 : (seen | {pexc === 1'b1, pfx === 1'b1, dbk === 1'b1, ibk === 1'b1});
   end

   // --------------------------------------------------------------------------
   // bus tasks
   // --------------------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic sup);
      @(posedge clk);
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      pp   <= {2'b00, sup};
      @(posedge clk);
      pen <= 1'b1;
      // request held until pready is seen high at an edge
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rd   = prd;
      err  = perr;
      priv = pexc;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b1);
   endtask

   task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] e, input logic sup,
                       input logic ee);
      apb(1'b0, a, 32'h0000_0000, sup);
      `CHK(s, e, rd)
      `CHK(s, ee, err)
   endtask

   // clear taken by the monitor itself at the next edge, so it never races an event
   task automatic clr;
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end

   // --------------------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------------------
   initial begin
      {rst_n, psel, pen, pwr, bl, bc, xu, cy, ov, et, rfi, dt, ten, fv, dv, dw} = '0;
      {pa, pp, ssel, clear, evt, pwd, ra, ea, dc, dad, fa, daddr} = '0;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rchk("state reset", 12'h000, 32'h0000_0000, 1'b1, 1'b0);
      `CHK("tag reset", 4'h0, tag)
      for (n = 0; n < 10; n++) wr(tab[n], 32'h5A5A_0000 | 32'(tab[n]));
      for (n = 0; n < 10; n++) rchk("rw", tab[n], 32'h5A5A_0000 | 32'(tab[n]), 1'b1, 1'b0);
      ssel <= 4'h3;
      repeat (2) @(posedge clk);
      #1 `CHK("segment out", 32'h5A5A_008C, sv)
      wr(12'h034, 32'hFFFF_FFFF);
      rchk("version", 12'h034, VERS, 1'b1, 1'b0);
      rchk("unmapped", 12'h05C, 32'h0000_0000, 1'b1, 1'b1);
      $display("test plain registers finished");
      // user privilege: refused where supervisor-only
      clr();
      apb(1'b1, 12'h000, 32'hDEAD_0000, 1'b0);
      `CHK("user deny", 2'b11, {err, priv})
      rchk("kept", 12'h000, 32'h0000_0000, 1'b1, 1'b0);
      wr(12'h010, 32'h0000_0100);
      apb(1'b1, 12'h010, 32'h0000_0000, 1'b0);
      `CHK("user tb write", 1'b1, err)
      rchk("user tb read", 12'h010, 32'h0000_0100, 1'b0, 1'b0);
      apb(1'b1, 12'h004, 32'h0000_0111, 1'b0);
      rchk("user link", 12'h004, 32'h0000_0111, 1'b0, 1'b0);
      $display("test privilege finished");
      // implicit updates from instruction events
      wr(12'h008, 32'h0000_0001);
      @(posedge clk);
      {ra, dc, dad} <= {32'h0000_4444, 32'h0200_0000, 32'h0000_0DA0};
      {bl, bc, xu, cy, ov, dt} <= '1;
      @(posedge clk);
      {bl, bc, xu, dt} <= '0;
      #1 `CHK("link target", 32'h0000_4444, lt)
      `CHK("count zero", 1'b1, czero)
      rchk("carry ovf", 12'h00C, 32'h6000_0000, 1'b1, 1'b0);
      rchk("fault cause", 12'h018, 32'h0200_0000, 1'b1, 1'b0);
      rchk("fault addr", 12'h01C, 32'h0000_0DA0, 1'b1, 1'b0);
      // exception entry and return
      wr(12'h000, 32'h0000_C0A5);
      ea <= 32'h0000_1000;
      et <= 1'b1;
      @(posedge clk);
      et <= 1'b0;
      #1 `CHK("resume", 32'h0000_1000, rs)
      `CHK("state on entry", 32'h0000_00A5, ms)
      rchk("saved status", 12'h02C, 32'h0000_C0A5, 1'b1, 1'b0);
      rfi <= 1'b1;
      @(posedge clk);
      rfi <= 1'b0;
      #1 `CHK("state restored", 32'h0000_C0A5, ms)
      $display("test events finished");
      // time base: 40 enabled cycles give exactly 10 ticks, carry into upper
      wr(12'h010, 32'hFFFF_FFFE);
      wr(12'h014, 32'h0000_0000);
      @(posedge clk);
      ten <= 1'b1;
      repeat (40) @(posedge clk);
      ten <= 1'b0;
      rchk("tb low", 12'h010, 32'h0000_0008, 1'b1, 1'b0);
      rchk("tb high", 12'h014, 32'h0000_0001, 1'b1, 1'b0);
      repeat (20) @(posedge clk);
      rchk("tb gated", 12'h010, 32'h0000_0008, 1'b1, 1'b0);
      // enabled time base must not move while the clock enable is low
      ten <= 1'b1;
      ce  <= 1'b0;
      repeat (20) @(posedge clk);
      {ce, ten} <= 2'b10;
      rchk("tb frozen", 12'h010, 32'h0000_0008, 1'b1, 1'b0);
      // decrementer: three ticks from 2 to underflow
      wr(12'h020, 32'h0000_0002);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dexc !== 1'b1 && n < 30);
      `CHK("dec delay", 1'b1, n >= 9 && n <= 14)
      $display("test timers finished");
      // control outputs
      wr(12'h030, 32'h8000_0000);
      #1 `CHK("ext access", 1'b1, eae)
      wr(12'h040, 32'h1234_5678);
      #1 `CHK("impl ctrl", 32'h1234_5678, ic)
      wr(12'h044, 32'hFFFF_FFF5);
      #1 `CHK("tag out", 4'h5, tag)
      rchk("tag read", 12'h044, 32'h0000_0005, 1'b1, 1'b0);
      // breakpoints: near miss first, then hit differing only in ignored low bits
      wr(12'h038, 32'h0000_3002);
      wr(12'h03C, 32'h0000_5001);
      clr();
      {fv, dv, fa, daddr} <= {2'b11, 32'h0000_3004, 32'h0000_5008};
      repeat (3) @(posedge clk);
      {fa, daddr} <= {32'h0000_3000, 32'h0000_5000};
      #1 `CHK("no match", 2'b00, seen[1:0])
      repeat (3) @(posedge clk);
      {fv, dv, fa} <= {2'b00, 32'h0000_2000};
      #1 `CHK("match", 2'b11, seen[1:0])
      $display("test breakpoints finished");
      // performance counter crossing its top bit
      wr(12'h048, 32'h7FFF_FFFE);
      wr(12'h050, 32'h0000_0108);
      clr();
      @(posedge clk);
      evt <= 8'h01;
      repeat (3) @(posedge clk);
      evt <= 8'h00;
      rchk("event count", 12'h048, 32'h8000_0001, 1'b1, 1'b0);
      `CHK("monitor exc", 1'b1, seen[2])
      rchk("sampled fetch", 12'h054, 32'h0000_2000, 1'b1, 1'b0);
      $display("test monitor finished");
      tally_and_finish();
   end
endmodule
`default_nettype wire
